// ===== rtl/sadc_sequencer.sv
// Purpose: Control and sequencing of an 8-bit successive-approximation ADC
// Assumes: sleep_i and internal_oscillator_tick_i are synchronous to mclk_i;
//          comp_i comes from the analog core and is resynchronised
// Notes:   dac_code_o is the result register, so the marker bit is the
//          trial bit offered to the DAC while each bit is resolved
// Notes on behaviour
// - Each conversion yields an 8-bit result.
// - Clock select picks system clock /16, /8, /4 or internal oscillator /4.
// - A conversion always lasts 13 conversion-clock periods.
// - Clock select changes take effect at the next conversion start.
// - Clock select returns to 11 on reset and wake; kept after conversions.
// - Pin map resets to 11, all three pins analog.
// - Pin map applies even while the converter is disabled.
// - Channel codes route inputs 0, 1, 2 or the 0.6V reference.
// - Channel change waits for conversion end; channel lost entering Sleep.
// - Writing go starts a conversion; hardware clears it when done.
// - Clearing go mid-conversion stops it; partial result kept.
// - Sleep entry clears go and stops any conversion.
// - Go cannot be set while the converter is disabled.
// - Result held through sampling, then cleared before resolution.
// - Marker one shifted right, bits msb first; done after 8 shifts.
// - Marker position in an aborted result shows bits resolved.
//
// Chosen here: strobed register access and the placing of the registers.
`timescale 1ns/1ps

module sadc_sequencer
    import sadc_pkg::*;
(
    // Clock and reset
    input  wire logic              mclk_i,
    input  wire logic              srst_i,
    // Register port
    input  wire logic [ADDR_W-1:0] addr_i,
    input  wire logic [7:0]        wdata_i,
    input  wire logic              wr_i,
    input  wire logic              rd_i,
    output logic      [7:0]        rdata_o,
    // System
    input  wire logic              sleep_i,
    input  wire logic              internal_oscillator_tick_i,
    // Analog core and multiplexer
    input  wire logic              comp_i,
    output logic      [2:0]        pin_analog_o,
    output logic      [1:0]        chan_sel_o,
    output logic                   sample_o,
    output logic                   core_en_o,
    output logic      [7:0]        dac_code_o,
    output logic                   done_o
);

    // Divisor length for a clock select code
    function automatic logic [4:0] div_len(input logic [1:0] sel);
        case (sel)
            ADCS_DIV16: div_len = DIV_16;
            ADCS_DIV8:  div_len = DIV_8;
            default:    div_len = DIV_4;
        endcase
    endfunction

    // Pins claimed by the pin map
    function automatic logic [2:0] ans_pins(input logic [1:0] ans);
        case (ans)
            2'h0:    ans_pins = 3'h0;
            2'h1:    ans_pins = 3'h4;
            2'h2:    ans_pins = 3'h5;
            default: ans_pins = 3'h7;
        endcase
    endfunction

    // One resolve step: trial bit takes the comparator, marker moves right
    function automatic logic [7:0] resolve_step(input logic [7:0] res,
                                                input logic       cmp);
        logic [7:0] mark;
        mark = res & (~res + 8'h01);
        resolve_step = (res & ~mark) | (cmp ? mark : 8'h00) | (mark >> 1);
    endfunction

    sadc_ctrl_t  ctrl_reg,   ctrl_next;
    sadc_state_t state_reg,  state_next;
    logic [7:0]  result_reg, result_next;
    logic [3:0]  tad_reg,    tad_next;
    logic [3:0]  divc_reg,   divc_next;
    logic [1:0]  act_div_reg, act_div_next;
    logic [1:0]  chan_reg,   chan_next;
    logic [2:0]  pin_reg,    pin_next;
    logic [7:0]  rdata_reg,  rdata_next;
    logic        done_reg,   done_next;
    logic        sample_reg, sample_next;
    logic        sleep_reg;
    logic        cmp1_reg, cmp2_reg, cmp3_reg, cmp_reg, cmp_next;
    logic        cnt_ev, tad_tick, start, busy;
    sadc_ctrl_t  wctrl;

    assign busy  = (state_reg != ST_IDLE);
    assign wctrl = sadc_ctrl_t'(wdata_i);

    // Comparator resync; a change counts once stages two and three agree
    assign cmp_next = (cmp2_reg == cmp3_reg) ? cmp3_reg : cmp_reg;

    // Internal-oscillator setting advances only on its ticks
    assign cnt_ev   = busy && (act_div_reg != ADCS_INTERNAL_OSCILLATOR || internal_oscillator_tick_i);
    assign tad_tick = cnt_ev
                      && ({1'b0, divc_reg} == div_len(act_div_reg) - 5'h01);

    always_comb
    begin
        ctrl_next    = ctrl_reg;
        state_next   = state_reg;
        result_next  = result_reg;
        tad_next     = tad_reg;
        divc_next    = divc_reg;
        act_div_next = act_div_reg;
        done_next    = 1'b0;
        rdata_next   = 8'h00;
        start        = 1'b0;

        if (cnt_ev)
        begin
            divc_next = tad_tick ? 4'h0 : divc_reg + 4'h1;
        end

        // Thirteen periods regardless of divisor
        if (tad_tick)
        begin
            tad_next = tad_reg + 4'h1;
            case (state_reg)
                ST_SAMPLE:
                begin
                    if (tad_reg == SAMPLE_TADS - 4'h1)
                    begin
                        result_next = RESULT_RST;
                        state_next  = ST_RESOLVE;
                    end
                end
                ST_RESOLVE:
                begin
                    if (tad_reg == SAMPLE_TADS)
                    begin
                        result_next = RES_MARKER;
                    end
                    else
                    begin
                        // Settled value, so a 4-cycle period sees the new trial
                        result_next = resolve_step(result_reg, cmp_next);
                    end
                    if (tad_reg == CONV_TADS - 4'h1)
                    begin
                        state_next = ST_IDLE;
                        done_next  = 1'b1;
                    end
                end
                default:
                begin
                    state_next = ST_IDLE;
                end
            endcase
        end

        if (wr_i && addr_i == REG_CTRL)
        begin
            ctrl_next = wctrl;
            if (busy)
            begin
                // Abort leaves the partial result; the marker shows its depth
                if (!wctrl.go || !wctrl.en)
                begin
                    state_next = ST_IDLE;
                end
                // A repeated go is absorbed here
            end
            else if (wctrl.go && wctrl.en && !sleep_i)
            begin
                start = 1'b1;
            end
        end

        if (start)
        begin
            state_next   = ST_SAMPLE;
            tad_next     = 4'h0;
            divc_next    = 4'h0;
            act_div_next = wctrl.adcs;
        end

        // Sleep entry stops the converter and drops the channel
        if (sleep_i && !sleep_reg)
        begin
            state_next    = ST_IDLE;
            ctrl_next.chs = CHS_RST;
        end
        if (!sleep_i && sleep_reg)
        begin
            ctrl_next.adcs = ADCS_RST;
        end

        ctrl_next.go = (state_next != ST_IDLE);
        sample_next  = (state_next == ST_SAMPLE);

        // Mux follows software only between conversions; 11 is the reference
        chan_next = (busy && state_next != ST_IDLE) ? chan_reg
                                                    : ctrl_next.chs;

        pin_next = ans_pins(ctrl_next.ans);
        if (ctrl_next.en && chan_next != 2'h3)
        begin
            pin_next[chan_next] = 1'b1;
        end

        if (rd_i)
        begin
            case (addr_i)
                REG_CTRL:   rdata_next = ctrl_reg;
                REG_RESULT: rdata_next = result_reg;
                default:    rdata_next = 8'h00;
            endcase
        end
    end

    always_ff @(posedge mclk_i)
    begin
        if (srst_i)
        begin
            ctrl_reg    <= sadc_ctrl_t'(CTRL_RST);
            state_reg   <= ST_IDLE;
            result_reg  <= RESULT_RST;
            tad_reg     <= 4'h0;
            divc_reg    <= 4'h0;
            act_div_reg <= ADCS_RST;
            chan_reg    <= CHS_RST;
            pin_reg     <= 3'h7;
            rdata_reg   <= 8'h00;
            done_reg    <= 1'b0;
            sample_reg  <= 1'b0;
            sleep_reg   <= 1'b0;
            cmp1_reg    <= 1'b0;
            cmp2_reg    <= 1'b0;
            cmp3_reg    <= 1'b0;
            cmp_reg     <= 1'b0;
        end
        else
        begin
            ctrl_reg    <= ctrl_next;
            state_reg   <= state_next;
            result_reg  <= result_next;
            tad_reg     <= tad_next;
            divc_reg    <= divc_next;
            act_div_reg <= act_div_next;
            chan_reg    <= chan_next;
            pin_reg     <= pin_next;
            rdata_reg   <= rdata_next;
            done_reg    <= done_next;
            sample_reg  <= sample_next;
            sleep_reg   <= sleep_i;
            cmp1_reg    <= comp_i;
            cmp2_reg    <= cmp1_reg;
            cmp3_reg    <= cmp2_reg;
            cmp_reg     <= cmp_next;
        end
    end

    assign rdata_o      = rdata_reg;
    assign pin_analog_o = pin_reg;
    assign chan_sel_o   = chan_reg;
    assign sample_o     = sample_reg;
    // Enable off gates the analog core fully
    assign core_en_o    = ctrl_reg.en;
    assign dac_code_o   = result_reg;
    assign done_o       = done_reg;

    // Busy-cycle counter, read only by the checks below
    logic [8:0] cyc_reg;
    always_ff @(posedge mclk_i)
    begin
        if (srst_i || state_next == ST_IDLE)
        begin
            cyc_reg <= 9'h000;
        end
        else
        begin
            cyc_reg <= start ? 9'h001 : cyc_reg + 9'h001;
        end
    end

    conv_length_a: assert property (@(posedge mclk_i) disable iff (srst_i)
        tad_tick && state_reg == ST_RESOLVE && tad_reg == 4'hC
        && act_div_reg != ADCS_INTERNAL_OSCILLATOR
        |-> cyc_reg == 9'(13 * div_len(act_div_reg)))
        else $error("conversion length wrong");

    tad_spacing_a: assert property (@(posedge mclk_i) disable iff (srst_i)
        tad_tick && act_div_reg == ADCS_DIV4 && tad_reg != 4'hC
        |=> (!tad_tick) [*3] ##1 (tad_tick || state_reg == ST_IDLE))
        else $error("period length wrong");

    div_held_a: assert property (@(posedge mclk_i) disable iff (srst_i)
        busy && $past(busy) |-> $stable(act_div_reg))
        else $error("divisor changed mid conversion");

    chan_held_a: assert property (@(posedge mclk_i) disable iff (srst_i)
        busy && $past(busy) |-> $stable(chan_sel_o))
        else $error("channel changed mid conversion");

    no_start_off_a: assert property (@(posedge mclk_i) disable iff (srst_i)
        wr_i && addr_i == REG_CTRL && !wdata_i[0]
        |=> !busy && !ctrl_reg.go)
        else $error("started while disabled");

    abort_keeps_a: assert property (@(posedge mclk_i) disable iff (srst_i)
        busy && wr_i && addr_i == REG_CTRL && !wdata_i[1]
        |=> !busy ##1 $stable(result_reg))
        else $error("abort lost result");

    sleep_stop_a: assert property (@(posedge mclk_i) disable iff (srst_i)
        sleep_i && !sleep_reg |=> !busy && !ctrl_reg.go)
        else $error("sleep did not stop");

    no_restart_a: assert property (@(posedge mclk_i) disable iff (srst_i)
        busy && wr_i && addr_i == REG_CTRL && wdata_i[1] && wdata_i[0]
        && state_next != ST_IDLE
        |=> cyc_reg == $past(cyc_reg) + 9'h001)
        else $error("go restarted conversion");

    sample_hold_a: assert property (@(posedge mclk_i) disable iff (srst_i)
        state_reg == ST_SAMPLE && $past(state_reg) == ST_SAMPLE
        |-> $stable(result_reg))
        else $error("result changed in sampling");

    marker_first_a: assert property (@(posedge mclk_i) disable iff (srst_i)
        tad_tick && state_reg == ST_RESOLVE && tad_reg == SAMPLE_TADS
        |=> result_reg == RES_MARKER ##1 result_reg[7:6] != 2'b00)
        else $error("marker not entered");

    done_pulse_a: assert property (@(posedge mclk_i)
        disable iff (srst_i) done_o |=> !done_o)
        else $error("done longer than a cycle");

endmodule

// ===== rtl/sadc_pkg.sv
// Purpose: Shared constants and types for the converter sequencer
// Assumes: 8-bit control and result registers on a plain strobe port
// Notes:   Offsets are word indices on the register port
package sadc_pkg;

    // Register port
    localparam int        ADDR_W      = 2;
    localparam logic [1:0] REG_CTRL   = 2'h0;
    localparam logic [1:0] REG_RESULT = 2'h1;

    // Control register layout, msb first
    typedef struct packed {
        logic [1:0] ans;   // analog_pin_map
        logic [1:0] adcs;  // conv_clock_select
        logic [1:0] chs;   // channel_select
        logic       go;    // start/done flag
        logic       en;    // converter_enable
    } sadc_ctrl_t;

    // Values after reset
    localparam logic [7:0] CTRL_RST   = 8'hFC;
    localparam logic [7:0] RESULT_RST = 8'h00;
    localparam logic [1:0] ADCS_RST   = 2'h3;
    localparam logic [1:0] CHS_RST    = 2'h3;

    // Conversion clock select codes and divisors
    localparam logic [1:0] ADCS_DIV16  = 2'h0;
    localparam logic [1:0] ADCS_DIV8   = 2'h1;
    localparam logic [1:0] ADCS_DIV4   = 2'h2;
    localparam logic [1:0] ADCS_INTERNAL_OSCILLATOR = 2'h3;
    localparam logic [4:0] DIV_16      = 5'h10;
    localparam logic [4:0] DIV_8       = 5'h08;
    localparam logic [4:0] DIV_4       = 5'h04;

    // Conversion timing in conversion-clock periods
    localparam logic [3:0] CONV_TADS   = 4'hD;
    localparam logic [3:0] SAMPLE_TADS = 4'h4;
    localparam logic [7:0] RES_MARKER  = 8'h80;

    // Sequencer states
    typedef enum logic [1:0] {
        ST_IDLE    = 2'b00,
        ST_SAMPLE  = 2'b01,
        ST_RESOLVE = 2'b10
    } sadc_state_t;

endpackage

// ===== tb/sadc_core_model.sv
// Purpose: Behavioural analog core, input mux and comparator
// Assumes: Levels are 8-bit codes, compared against the DAC code
// Notes:   Output toggles while the core is off, so no stale level helps
`timescale 1ns/1ps

module sadc_core_model
    import sadc_pkg::*;
#(
    parameter logic [7:0] REF_CODE = 8'h1F
)
(
    // Clock
    input  wire logic       mclk_i,
    // Sequencer side
    input  wire logic       en_i,
    input  wire logic [1:0] chan_i,
    input  wire logic [7:0] dac_i,
    // Analog levels
    input  wire logic [7:0] vin0_i,
    input  wire logic [7:0] vin1_i,
    input  wire logic [7:0] vin2_i,
    output logic            comp_o
);
    logic [7:0] level;
    logic       junk_reg = 1'b0;

    always @(posedge mclk_i)
        junk_reg <= ~junk_reg;

    always_comb
    begin
        case (chan_i)
            2'h0:    level = vin0_i;
            2'h1:    level = vin1_i;
            2'h2:    level = vin2_i;
            default: level = REF_CODE;
        endcase
        comp_o = en_i ? (level >= dac_i) : junk_reg;
    end
endmodule

// ===== tb/tb_sadc_sequencer.sv
// Purpose: Self-checking bench for the converter sequencer
// Assumes: Analog core model answers from fixed random levels
// Notes:   Internal-oscillator tick comes every 4 clocks
`timescale 1ns/1ps

module tb_sadc_sequencer;
    import sadc_pkg::*;

    logic              mclk_i  = 1'b0;
    logic              srst_i  = 1'b1;
    logic [ADDR_W-1:0] addr_i  = 2'h0;
    logic [7:0]        wdata_i = 8'h00;
    logic              wr_i    = 1'b0;
    logic              rd_i    = 1'b0;
    logic              sleep_i = 1'b0;
    logic              tick_reg = 1'b0;
    logic [1:0]        tdiv_reg = 2'h0;
    logic              comp_i;
    logic [7:0]        rdata_o;
    logic [7:0]        dac_code_o;
    logic [2:0]        pin_analog_o;
    logic [1:0]        chan_sel_o;
    logic              sample_o;
    logic              core_en_o;
    logic              done_o;
    logic [7:0]        vin [3];
    logic [2:0]        pm [4] = '{3'h0, 3'h4, 3'h5, 3'h7};
    logic [7:0]        rv;
    logic [7:0]        ev;
    logic [7:0]        prev;
    logic [1:0]        cc;
    int                err_total   = 0;
    int                checks_done = 0;
    int                seed        = 32'h13BF26A5;
    int                n;

    initial
    begin
        forever #5 mclk_i = ~mclk_i;
    end

    always @(posedge mclk_i)
    begin
        tdiv_reg <= tdiv_reg + 2'h1;
        tick_reg <= (tdiv_reg == 2'h3);
    end

    sadc_sequencer dut_u (.mclk_i(mclk_i), .srst_i(srst_i), .addr_i(addr_i),
        .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
        .sleep_i(sleep_i), .internal_oscillator_tick_i(tick_reg), .comp_i(comp_i),
        .pin_analog_o(pin_analog_o), .chan_sel_o(chan_sel_o),
        .sample_o(sample_o), .core_en_o(core_en_o),
        .dac_code_o(dac_code_o), .done_o(done_o));

    sadc_core_model core_u (.mclk_i(mclk_i), .en_i(core_en_o),
        .chan_i(chan_sel_o), .dac_i(dac_code_o), .vin0_i(vin[0]),
        .vin1_i(vin[1]), .vin2_i(vin[2]), .comp_o(comp_i));

    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            err_total++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        wr_i    <= 1'b1;
        addr_i  <= a;
        wdata_i <= d;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask

    task automatic rd(input logic [1:0] a, output logic [7:0] d);
        @(posedge mclk_i);
        rd_i   <= 1'b1;
        addr_i <= a;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1 d = rdata_o;
    endtask

    // Bounded wait; a lost done pulse ends the run
    task automatic wait_done(input int lim, output int cnt);
        cnt = 0;
        while (done_o !== 1'b1)
        begin
            @(posedge mclk_i);
            #1 cnt++;
            if (cnt > lim)
            begin
                err_total++;
                conclude();
            end
        end
    endtask

    // Resolved bits above the marker must match the input level
    function automatic logic [7:0] part_exp(input logic [7:0] r,
                                            input logic [7:0] v);
        logic [7:0] low;
        low = r & (~r + 8'h01);
        return (v & ~((low << 1) - 8'h01)) | low;
    endfunction

    initial
    begin
        vin = '{8'h00, 8'h00, 8'h00};
        repeat (8) @(posedge mclk_i);
        srst_i <= 1'b0;
        rd(2'h0, rv);
        chk(rv, 8'hFC);
        chk({5'h00, pin_analog_o}, 8'h07);
        chk({6'h00, chan_sel_o}, 8'h03);
        wr(2'h1, 8'hAA);
        rd(2'h1, rv);
        chk(rv, 8'h00);
        wr(2'h0, 8'hFE);
        rd(2'h0, rv);
        chk(rv, 8'hFC);
        $display("test reset done");
        for (int m = 0; m < 4; m++)
        begin
            wr(2'h0, {2'(m), 6'h3C});
            repeat (2) @(posedge mclk_i);
            #1 chk({5'h00, pin_analog_o}, {5'h00, pm[m]});
            wr(2'h0, {2'(m), 2'h3, 2'(m), 2'h1});
            repeat (2) @(posedge mclk_i);
            ev = {5'h00, pm[m] | ((m < 3) ? 3'(1 << m) : 3'h0)};
            #1 chk({5'h00, pin_analog_o}, ev);
            chk({7'h00, core_en_o}, 8'h01);
        end
        $display("test pin map done");
        prev = 8'h00;
        for (int c = 0; c < 4; c++)
        begin
            cc = 2'(c);
            for (int i = 0; i < 3; i++)
                vin[i] = 8'($random(seed));
            if (c < 2)
                vin[c] = (c == 1) ? 8'hFF : 8'h00;
            ev = (c == 3) ? 8'h1F : vin[c];
            wr(2'h0, {2'h3, cc, cc, 2'h3});
            wr(2'h0, {2'h3, cc ^ 2'h1, cc ^ 2'h1, 2'h3});
            repeat (2) @(posedge mclk_i);
            #1 chk(dac_code_o, prev);
            chk({7'h00, sample_o}, 8'h01);
            chk({6'h00, chan_sel_o}, {6'h00, cc});
            wait_done(400, n);
            if (c < 3)
                chk(8'(n), 8'(13 * (16 >> c) - 4));
            rd(2'h1, rv);
            chk(rv, ev);
            rd(2'h0, rv);
            chk(rv, {2'h3, cc ^ 2'h1, cc ^ 2'h1, 2'h1});
            chk({6'h00, chan_sel_o}, {6'h00, cc ^ 2'h1});
            chk({7'h00, sample_o}, 8'h00);
            prev = ev;
        end
        $display("test conversions done");
        vin[0] = 8'($random(seed));
        wr(2'h0, 8'hC3);
        repeat (120) @(posedge mclk_i);
        wr(2'h0, 8'hC1);
        n = 0;
        repeat (300)
        begin
            @(posedge mclk_i);
            #1 n = n + int'(done_o === 1'b1);
        end
        chk(8'(n), 8'h00);
        rd(2'h1, rv);
        chk(8'(rv == 8'h00), 8'h00);
        chk(rv, part_exp(rv, vin[0]));
        chk(rv, (vin[0] & 8'hC0) | 8'h20);
        rd(2'h1, ev);
        chk(ev, rv);
        rd(2'h0, rv);
        chk(rv, 8'hC1);
        $display("test abort done");
        wr(2'h0, 8'hC7);
        repeat (30) @(posedge mclk_i);
        sleep_i <= 1'b1;
        rd(2'h0, rv);
        chk(rv, 8'hCD);
        chk({6'h00, chan_sel_o}, 8'h03);
        @(posedge mclk_i);
        sleep_i <= 1'b0;
        rd(2'h0, rv);
        chk(rv, 8'hFD);
        $display("test sleep done");
        conclude();
    end
endmodule
